/* File: rtl/aspm_cfg.sv */
// link power management configuration with AXI4-Lite registers
// assumes inputs synchronous to CLK_I; one write and one read at a time
//
// What this block does
// - Transmitter enters L0s only after link idle for threshold, 256 ns steps.
// - Default idle threshold stays at or below 7 microseconds.
// - Integrated transceiver option forces largest idle threshold.
// - L0s acceptable latency reported read-only in device capabilities.
// - Common-clock FTS count advertised and used for L0s exit latency.
// - Separate-clock FTS count advertised and used for L0s exit latency.
// - L1 support bit follows enable, cleared with integrated transceiver.
// - L1 acceptable latency reported read-only in device capabilities.
// - Two L1 exit latency settings derive the L1 exit latency field.
`timescale 1ns/1ps
`default_nettype none
module aspm_cfg #(
  parameter int CNT_W = 9
) (
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RESET_I,
  // axi4-lite write address
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [7:0]  S_AXI_AWADDR_I,
  // axi4-lite write data
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  // axi4-lite write response
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  output logic [1:0]       S_AXI_BRESP_O,
  // axi4-lite read address
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  input  wire logic [7:0]  S_AXI_ARADDR_I,
  // axi4-lite read data
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  // link side
  input  wire logic        LINK_IDLE_I,
  output logic             TX_L0S_O,
  output logic [7:0]       FTS_COUNT_O,
  // capability fields
  output logic             ASPM_L1_SUP_O,
  output logic [2:0]       L0S_ACC_LAT_O,
  output logic [2:0]       L1_ACC_LAT_O,
  output logic [2:0]       L0S_EXIT_LAT_O,
  output logic [2:0]       L1_EXIT_LAT_O
);

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  if (CNT_W < 9) begin : g_chk
    $error("CNT_W too small for the largest idle threshold");
  end

  // byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  logic [31:0] ctrl_reg;
  logic [31:0] fts_reg;
  logic [31:0] lat_reg;

  // write channel state
  logic        aw_hold_reg;
  logic [7:0]  aw_addr_reg;
  logic        w_hold_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        aw_fire;
  logic        w_fire;
  logic        do_write;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;

  // read channel state
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        ar_fire;

  // derived configuration
  logic        xcvr_sel;
  logic        cclk_sel;
  logic [4:0]  thr_code;
  logic [CNT_W-1:0] thr_cyc;
  logic [7:0]  fts_cc;
  logic [7:0]  fts_sc;
  logic [7:0]  fts_sel;
  logic [2:0]  l1x_sel;
  logic        l1_sup;
  logic [31:0] devcap;
  logic [31:0] lnkcap;
  logic        l0s_state;

  assign S_AXI_AWREADY_O = !aw_hold_reg && !bvalid_reg;
  assign S_AXI_WREADY_O  = !w_hold_reg && !bvalid_reg;
  assign aw_fire  = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
  assign w_fire   = S_AXI_WVALID_I && S_AXI_WREADY_O;
  assign do_write = (aw_hold_reg || aw_fire) && (w_hold_reg || w_fire);
  assign wr_addr  = aw_hold_reg ? aw_addr_reg : S_AXI_AWADDR_I;
  assign wr_data  = w_hold_reg ? w_data_reg : S_AXI_WDATA_I;
  assign wr_strb  = w_hold_reg ? w_strb_reg : S_AXI_WSTRB_I;

  always_ff @(posedge CLK_I) begin
    if (RESET_I || do_write) begin
      aw_hold_reg <= 1'b0;
    end else if (aw_fire) begin
      aw_hold_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (aw_fire) begin
      aw_addr_reg <= S_AXI_AWADDR_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I || do_write) begin
      w_hold_reg <= 1'b0;
    end else if (w_fire) begin
      w_hold_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (w_fire) begin
      w_data_reg <= S_AXI_WDATA_I;
      w_strb_reg <= S_AXI_WSTRB_I;
    end
  end

  // register writes, read-only ones ignore data
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      ctrl_reg <= aspm_pkg::CTRL_RST;
      fts_reg  <= aspm_pkg::FTS_RST;
      lat_reg  <= aspm_pkg::LAT_RST;
    end else if (do_write) begin
      unique case (wr_addr)
        aspm_pkg::OFS_CTRL: ctrl_reg <= merge(ctrl_reg, wr_data, wr_strb)
                                        & 32'h0000_01F7;
        aspm_pkg::OFS_FTS:  fts_reg  <= merge(fts_reg, wr_data, wr_strb)
                                        & 32'h0000_FFFF;
        aspm_pkg::OFS_LAT:  lat_reg  <= merge(lat_reg, wr_data, wr_strb)
                                        & 32'h0000_0FFF;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (wr_addr[1:0] == 2'b00 &&
                     wr_addr <= aspm_pkg::OFS_STAT) ? RESP_OKAY
                                                    : RESP_SLVERR;
    end else if (S_AXI_BREADY_I) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign S_AXI_BVALID_O = bvalid_reg;
  assign S_AXI_BRESP_O  = bresp_reg;

  // read path
  assign S_AXI_ARREADY_O = !rvalid_reg;
  assign ar_fire = S_AXI_ARVALID_I && S_AXI_ARREADY_O;

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= RESP_OKAY;
      unique case (S_AXI_ARADDR_I)
        aspm_pkg::OFS_CTRL:   rdata_reg <= ctrl_reg;
        aspm_pkg::OFS_FTS:    rdata_reg <= fts_reg;
        aspm_pkg::OFS_LAT:    rdata_reg <= lat_reg;
        aspm_pkg::OFS_DEVCAP: rdata_reg <= devcap;
        aspm_pkg::OFS_LNKCAP: rdata_reg <= lnkcap;
        aspm_pkg::OFS_STAT:   rdata_reg <= {16'h0000, fts_sel,
                                            6'h00, l0s_state,
                                            LINK_IDLE_I};
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RREADY_I) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign S_AXI_RVALID_O = rvalid_reg;
  assign S_AXI_RDATA_O  = rdata_reg;
  assign S_AXI_RRESP_O  = rresp_reg;

  // configuration decode
  assign xcvr_sel = ctrl_reg[aspm_pkg::CTRL_XCVR_BIT];
  assign cclk_sel = ctrl_reg[aspm_pkg::CTRL_CCLK_BIT];
  assign fts_cc   = fts_reg[aspm_pkg::FTS_CC_LSB +: 8];
  assign fts_sc   = fts_reg[aspm_pkg::FTS_SC_LSB +: 8];

  // reset code keeps under 7 us
  assign thr_code = xcvr_sel ? aspm_pkg::THR_MAX
                             : ctrl_reg[aspm_pkg::CTRL_THR_LSB +: 5];

  assign thr_cyc = CNT_W'(aspm_pkg::idle_cycles(thr_code));

  aspm_idle_timer #(
    .CNT_W (CNT_W)
  ) u_idle_timer (
    .clk_i  (CLK_I),
    .rst_i  (RESET_I),
    .idle_i (LINK_IDLE_I),
    .thr_i  (thr_cyc),
    .l0s_o  (l0s_state)
  );

  assign TX_L0S_O = l0s_state;

  assign fts_sel = cclk_sel ? fts_cc : fts_sc;
  assign l1x_sel = cclk_sel ? lat_reg[aspm_pkg::LAT_L1X_CC_LSB +: 3]
                            : lat_reg[aspm_pkg::LAT_L1X_SC_LSB +: 3];

  assign l1_sup = ctrl_reg[aspm_pkg::CTRL_L1EN_BIT] && !xcvr_sel;

  // capability words
  always_comb begin
    devcap = 32'h0000_0000;
    devcap[aspm_pkg::DEVCAP_L0S_LSB +: 3] =
      lat_reg[aspm_pkg::LAT_L0S_ACC_LSB +: 3];
    devcap[aspm_pkg::DEVCAP_L1_LSB +: 3] =
      lat_reg[aspm_pkg::LAT_L1_ACC_LSB +: 3];
  end

  always_comb begin
    lnkcap = 32'h0000_0000;
    lnkcap[aspm_pkg::LNKCAP_L0S_BIT] = 1'b1;
    lnkcap[aspm_pkg::LNKCAP_L1_BIT]  = l1_sup;
    lnkcap[aspm_pkg::LNKCAP_L0SX_LSB +: 3] =
      aspm_pkg::l0s_exit_code(fts_sel);
    lnkcap[aspm_pkg::LNKCAP_L1X_LSB +: 3] = l1x_sel;
  end

  // registered capability and link outputs
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      FTS_COUNT_O    <= 8'h00;
      ASPM_L1_SUP_O  <= 1'b0;
      L0S_ACC_LAT_O  <= 3'h0;
      L1_ACC_LAT_O   <= 3'h0;
      L0S_EXIT_LAT_O <= 3'h0;
      L1_EXIT_LAT_O  <= 3'h0;
    end else begin
      FTS_COUNT_O    <= fts_sel;
      ASPM_L1_SUP_O  <= lnkcap[aspm_pkg::LNKCAP_L1_BIT];
      L0S_ACC_LAT_O  <= devcap[aspm_pkg::DEVCAP_L0S_LSB +: 3];
      L1_ACC_LAT_O   <= devcap[aspm_pkg::DEVCAP_L1_LSB +: 3];
      L0S_EXIT_LAT_O <= lnkcap[aspm_pkg::LNKCAP_L0SX_LSB +: 3];
      L1_EXIT_LAT_O  <= lnkcap[aspm_pkg::LNKCAP_L1X_LSB +: 3];
    end
  end

endmodule : aspm_cfg
`default_nettype wire

/* File: inc/aspm_pkg.sv */
// package: register map, field layout, reset values and timing constants
// assumes a 40 MHz block clock and 32-bit AXI4-Lite register access
package aspm_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_FTS    = 8'h04;
  localparam logic [7:0] OFS_LAT    = 8'h08;
  localparam logic [7:0] OFS_DEVCAP = 8'h0C;
  localparam logic [7:0] OFS_LNKCAP = 8'h10;
  localparam logic [7:0] OFS_STAT   = 8'h14;

  // control fields
  localparam int CTRL_XCVR_BIT = 0;
  localparam int CTRL_L1EN_BIT = 1;
  localparam int CTRL_CCLK_BIT = 2;
  localparam int CTRL_THR_LSB  = 4;
  localparam int THR_W         = 5;
  localparam logic [4:0] THR_MAX = 5'h1F;

  // fts fields
  localparam int FTS_CC_LSB = 0;
  localparam int FTS_SC_LSB = 8;

  // latency setting fields, three-bit codes
  localparam int LAT_L0S_ACC_LSB = 0;
  localparam int LAT_L1_ACC_LSB  = 3;
  localparam int LAT_L1X_CC_LSB  = 6;
  localparam int LAT_L1X_SC_LSB  = 9;

  // capability fields
  localparam int DEVCAP_L0S_LSB = 6;
  localparam int DEVCAP_L1_LSB  = 9;
  localparam int LNKCAP_L0S_BIT = 10;
  localparam int LNKCAP_L1_BIT  = 11;
  localparam int LNKCAP_L0SX_LSB = 12;
  localparam int LNKCAP_L1X_LSB  = 15;

  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_01A6;
  localparam logic [31:0] FTS_RST  = 32'h0000_4020;
  localparam logic [31:0] LAT_RST  = 32'h0000_0000;

  // timing
  localparam int IDLE_STEP_NS  = 256;
  localparam int CLK_PERIOD_PS = 25000;
  localparam int FTS_NS        = 16;

  // idle threshold in cycles, rounded up
  function automatic logic [8:0] idle_cycles(input logic [4:0] code);
    int unsigned ps;
    ps = (int'(code) + 1) * IDLE_STEP_NS * 1000;
    return 9'((ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  endfunction : idle_cycles

  // l0s exit latency code from a fast training sequence count
  function automatic logic [2:0] l0s_exit_code(input logic [7:0] fts);
    int unsigned ns;
    ns = int'(fts) * FTS_NS;
    if (ns < 64)        return 3'h0;
    else if (ns < 128)  return 3'h1;
    else if (ns < 256)  return 3'h2;
    else if (ns < 512)  return 3'h3;
    else if (ns < 1024) return 3'h4;
    else if (ns < 2048) return 3'h5;
    else if (ns < 4096) return 3'h6;
    else                return 3'h7;
  endfunction : l0s_exit_code

endpackage : aspm_pkg

/* File: rtl/aspm_idle_timer.sv */
// idle timer: raises the l0s request after a run of idle cycles
// assumes idle_i is synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module aspm_idle_timer #(
  parameter int CNT_W = 9
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // idle level and threshold in cycles
  input  wire logic             idle_i,
  input  wire logic [CNT_W-1:0] thr_i,
  // transmitter in l0s
  output logic                  l0s_o
);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  assign cnt_next = (cnt_reg >= thr_i) ? cnt_reg : cnt_reg + 1'b1;

  always_ff @(posedge clk_i) begin
    if (rst_i || !idle_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !idle_i) begin
      l0s_o <= 1'b0;
    end else if (cnt_reg + 1'b1 >= thr_i) begin
      l0s_o <= 1'b1;
    end
  end

endmodule : aspm_idle_timer
`default_nettype wire

/* File: bench/aspm_cfg_props.sv */
// checker: bus handshake and link power assertions on the top ports
// assumes it is bound into aspm_cfg, single clock domain
`timescale 1ns/1ps
`default_nettype none
module aspm_cfg_props #(
  parameter int CNT_W = 9
) (
  input wire logic        CLK_I,
  input wire logic        RESET_I,
  input wire logic        S_AXI_AWVALID_I,
  input wire logic        S_AXI_AWREADY_O,
  input wire logic        S_AXI_WVALID_I,
  input wire logic        S_AXI_WREADY_O,
  input wire logic        S_AXI_BVALID_O,
  input wire logic        S_AXI_BREADY_I,
  input wire logic [1:0]  S_AXI_BRESP_O,
  input wire logic        S_AXI_ARVALID_I,
  input wire logic        S_AXI_ARREADY_O,
  input wire logic        S_AXI_RVALID_O,
  input wire logic        S_AXI_RREADY_I,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic        LINK_IDLE_I,
  input wire logic        TX_L0S_O,
  input wire logic [7:0]  FTS_COUNT_O,
  input wire logic [2:0]  L0S_EXIT_LAT_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  logic [9:0] run_reg;
  // consecutive idle samples, saturating
  always_ff @(posedge CLK_I) begin
    if (RESET_I || !LINK_IDLE_I) run_reg <= 10'h000;
    else if (run_reg != 10'h3FF) run_reg <= run_reg + 10'h001;
  end
  function automatic logic [2:0] exp_code(input logic [7:0] f);
    exp_code = 3'h6;
    for (int k = 5; k >= 0; k--) if (f < (8'h04 << k)) exp_code = 3'(k);
  endfunction : exp_code
  l0s_entry_a: assert property (
    $rose(TX_L0S_O) |-> run_reg >= 10'h00B) else $error("l0s too early");
  l0s_drop_a: assert property (
    TX_L0S_O && !LINK_IDLE_I |=> !TX_L0S_O) else $error("l0s held");
  exit_code_a: assert property (
    $stable(FTS_COUNT_O)[*2] |-> L0S_EXIT_LAT_O == exp_code(FTS_COUNT_O))
    else $error("l0s exit code wrong");
  bresp_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
    |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O)) else $error("b dropped");
  rdata_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
    |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O)) else $error("r dropped");
  wr_answer_a: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O &&
    S_AXI_WVALID_I && S_AXI_WREADY_O |=> S_AXI_BVALID_O)
    else $error("no write response");
  rd_answer_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O
    |=> S_AXI_RVALID_O) else $error("no read data");
  b_block_a: assert property (S_AXI_BVALID_O
    |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O) else $error("write not held");
  r_block_a: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
    else $error("read not held");
endmodule : aspm_cfg_props
`default_nettype wire

/* File: bench/link_partner.sv */
// partner: remote port that keeps the link idle or busy
// assumes the bench sets want_idle_i just after clock edges
`timescale 1ns/1ps
`default_nettype none
module link_partner (
  input  wire logic clk_i,
  input  wire logic want_idle_i,
  output wire logic idle_o
);
  // busy until the bench asks for idle
  logic idle_reg = 1'b0;
  always @(posedge clk_i) idle_reg <= want_idle_i;
  assign idle_o = idle_reg;
endmodule : link_partner
`default_nettype wire

/* File: bench/aspm_cfg_tb_top.sv */
// testbench: register access over the bus and idle runs from the partner
// assumes aspm_cfg with its reset configuration
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module aspm_cfg_tb_top;
  logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0;
  logic arv = 1'b0, rry = 1'b0, want = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0000_0000, v, rdat;
  logic [3:0] ws = 4'hF;
  logic awr, wrdy, bv, arr, rv, l0s, sup, idle;
  logic [1:0] br, rr, rs;
  logic [7:0] fts;
  logic [2:0] l0a, l1a, l0x, l1x;
  int n_errors = 0, n_tests = 0, hit;
  always #12.5 clk = ~clk;
  aspm_cfg dut (.CLK_I(clk), .RESET_I(rst),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_AWADDR_I(awa),
    .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy), .S_AXI_WDATA_I(wd),
    .S_AXI_WSTRB_I(ws), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry),
    .S_AXI_BRESP_O(br), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_ARADDR_I(ara), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry),
    .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rr), .LINK_IDLE_I(idle),
    .TX_L0S_O(l0s), .FTS_COUNT_O(fts), .ASPM_L1_SUP_O(sup),
    .L0S_ACC_LAT_O(l0a), .L1_ACC_LAT_O(l1a), .L0S_EXIT_LAT_O(l0x),
    .L1_EXIT_LAT_O(l1x));
  link_partner lp (.clk_i(clk), .want_idle_i(want), .idle_o(idle));
  task automatic report_and_stop;
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
      if (bv) break;
    end
    bry <= 1'b0;
    rs = br;
    // one quiet edge before the next request
    @(posedge clk);
    if (k == 40) begin n_errors++; report_and_stop(); end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int k;
    ara <= a; arv <= 1'b1; rry <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv) break;
    end
    rry <= 1'b0;
    v = rdat;
    rs = rr;
    @(posedge clk);
    if (k == 40) begin n_errors++; report_and_stop(); end
  endtask : rd
  task automatic settle;
    repeat (2) @(posedge clk);
  endtask : settle
  task automatic idle_run(input int n);
    hit = 0;
    want <= 1'b1;
    for (int i = 1; i <= n; i++) begin
      @(posedge clk);
      if (hit == 0 && l0s === 1'b1) hit = i;
    end
    want <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : idle_run
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h00); `CHK(v[8:4] <= 5'h1A, 1'b1)
    rd(8'h10); `CHK(v, 32'h0000_4C00)
    `CHK(sup, 1'b1)
    `CHK(fts, 8'h20)
    `CHK(l0x, 3'h4)
    rd(8'h18); `CHK(rs, 2'h2)
    `CHK(v, 32'h0000_0000)
    wr(8'h18, 32'h0000_0000); `CHK(rs, 2'h2)
    $display("reset test done");
    wr(8'h04, 32'h0000_FF03); settle(); `CHK(fts, 8'h03)
    `CHK(l0x, 3'h0)
    wr(8'h00, 32'h0000_01A2); settle(); `CHK(fts, 8'hFF)
    `CHK(l0x, 3'h6)
    ws <= 4'h2;
    wr(8'h04, 32'h0000_1177); settle(); `CHK(fts, 8'h11)
    ws <= 4'hF;
    `CHK(l0x, 3'h3)
    rd(8'h04); `CHK(v, 32'h0000_1103)
    $display("fts test done");
    wr(8'h08, 32'h0000_0E9D); settle(); `CHK(l0a, 3'h5)
    `CHK(l1a, 3'h3)
    `CHK(l1x, 3'h7)
    wr(8'h0C, 32'hFFFF_FFFF); rd(8'h0C); `CHK(v, 32'h0000_0740)
    wr(8'h00, 32'h0000_01A6); settle(); `CHK(l1x, 3'h2)
    $display("latency test done");
    wr(8'h00, 32'h0000_01A4); settle(); `CHK(sup, 1'b0)
    wr(8'h00, 32'h0000_01A7); settle(); `CHK(sup, 1'b0)
    rd(8'h10); `CHK(v[11], 1'b0)
    $display("l1 test done");
    wr(8'h00, 32'h0000_0006); idle_run(9); `CHK(hit, 0)
    idle_run(20); `CHK(hit >= 12 && hit <= 15, 1'b1)
    wr(8'h00, 32'h0000_0007); idle_run(320); `CHK(hit, 0)
    idle_run(340); `CHK(hit >= 329 && hit <= 332, 1'b1)
    rd(8'h14); `CHK(v, 32'h0000_0300)
    $display("idle test done");
    report_and_stop();
  end
endmodule : aspm_cfg_tb_top
bind aspm_cfg aspm_cfg_props #(.CNT_W(CNT_W)) chk (.*);
`default_nettype wire
